// ===== verilog/pmv_regs.vh
// Constants for the power mode and vector controller.
// Assumes a 100 MHz core clock and a 16-bit CPU address space.
//
// Operation
// - One run state plus five sleep levels, chosen by a software mode write.
// - Any interrupt wakes from sleep; return restores the former sleep level.
// - Run state keeps CPU, main, sub-main and auxiliary clocks enabled.
// - Sleep level 0 halts CPU and main clock; auxiliary and sub-main run.
// - Level 1 as level 0, oscillator generator off unless it feeds run state.
// - Level 2 stops CPU, main, sub-main; generator on; auxiliary clock runs.
// - Level 3 stops CPU, main, sub-main and generator; only auxiliary runs.
// - Level 4 stops every clock, the generator and the crystal.
// - Wake-up from any sleep level to run state takes under one microsecond.
// - Vectors sit in the table top; each 16-bit entry loads the PC.
// - Reset vector reading all ones after power-up enters sleep level 4.
// - Instruction fetch from peripheral or unused space causes system reset.
// - Partly maskable sources obey their own enable, not the global enable.
// - Nonmaskable sources ignore both the own and the global enable.
// - Key word first value disables boot loader; zero blocks erase on bad pass.
// - Lower unused table words are never fetched as vectors.
// - Serial B receive vector: receive flag in SPI, four status flags in I2C.
// - Serial B transmit vector: transmit in UART/SPI, both flags in I2C.
// - Unassigned control bit positions have no storage.
`ifndef PMV_REGS_VH
`define PMV_REGS_VH

// ----------------------------------------------------------------------------
// Mode codes
// ----------------------------------------------------------------------------
`define PMV_MODE_RUN     3'h0
`define PMV_MODE_SLEEP0  3'h1
`define PMV_MODE_SLEEP1  3'h2
`define PMV_MODE_SLEEP2  3'h3
`define PMV_MODE_SLEEP3  3'h4
`define PMV_MODE_SLEEP4  3'h5

// ----------------------------------------------------------------------------
// Memory map and table layout
// ----------------------------------------------------------------------------
`define PMV_TABLE_BASE   16'hFFC0
`define PMV_TABLE_TOP    16'hFFFF
`define PMV_RESET_VEC    16'hFFFE
`define PMV_UNUSED_TOP   16'hFFDC
`define PMV_BLANK_WORD   16'hFFFF
`define PMV_PERIPH_LO    16'h0000
`define PMV_PERIPH_HI    16'h01FF
`define PMV_KEY_NO_BOOT  16'hAA55
`define PMV_KEY_NO_ERASE 16'h0000

// ----------------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------------
`define PMV_CLK_MHZ      100
`define PMV_WAKE_MAX_NS  1000
`define PMV_WAKE_MAX_CYC ((`PMV_WAKE_MAX_NS * `PMV_CLK_MHZ) / 1000 - 1)
`define PMV_SETTLE_CYC   4'h8

`endif

// ===== verilog/pmv_power_mode_and_vector_ctrl.v
// Power mode sequencer, interrupt arbiter and vector fetch controller.
// Assumes the CPU and every interrupt source run on clk, so no input is
// synchronised; the CPU acts on pcLoad/vecAddr and pulses handlerReturn.
`include "pmv_regs.vh"
`default_nettype none

module pmv_power_mode_and_vector_ctrl #(
	parameter [15:0] RAM_LO      = 16'h0200,
	parameter [15:0] RAM_HI      = 16'h09FF,
	parameter [15:0] FLASH_LO    = 16'h8000,
	parameter integer SERB_RX_IDX = 23,
	parameter integer SERB_TX_IDX = 22,
	parameter [31:0] NMI_MASK    = 32'h4000_0000,
	parameter [31:0] PART_MASK   = 32'h2000_0000
) (
	input  wire        clk,
	input  wire        resetn,
	input  wire        modeWr,
	input  wire [2:0]  modeSel,
	input  wire        dcoIsMainSrc,
	input  wire        globalIntEn,
	input  wire [31:0] irqReq,
	input  wire [31:0] irqEn,
	input  wire        serialBI2c,
	input  wire        serialBSpi,
	input  wire        serialBReceiveFlag,
	input  wire        serialBTransmitFlag,
	input  wire        arbitrationLostFlag,
	input  wire        noAckFlag,
	input  wire        startSeenFlag,
	input  wire        stopSeenFlag,
	input  wire        handlerReturn,
	input  wire        fetchStb,
	input  wire [15:0] fetchAddr,
	input  wire [15:0] resetVecWord,
	input  wire [15:0] bootLoaderKeyWord,
	output reg         cpuRun_r,
	output reg         mainClkEn_r,
	output reg         subMainClkEn_r,
	output reg         auxClkEn_r,
	output reg         dcoGenEn_r,
	output reg         crystalEn_r,
	output reg  [2:0]  curMode_r,
	output reg         pcLoad_r,
	output reg  [15:0] vecAddr_r,
	output reg         sysReset_r,
	output reg         bootLoaderOff_r,
	output reg         eraseGuard_r
);

	// ------------------------------------------------------------------------
	// Sequencer states
	// ------------------------------------------------------------------------
	localparam [2:0] ST_BOOT    = 3'h0;
	localparam [2:0] ST_RUN     = 3'h1;
	localparam [2:0] ST_SLEEP   = 3'h2;
	localparam [2:0] ST_WAKE    = 3'h3;
	localparam [2:0] ST_SERVICE = 3'h4;

	// Lowest table slot that may hold a live vector; the word above the unused
	// region holds the key word, so live vectors start one slot higher.
	localparam integer USED_LO = (`PMV_UNUSED_TOP - `PMV_TABLE_BASE) / 2 + 2;
	localparam integer RESET_IDX = (`PMV_RESET_VEC - `PMV_TABLE_BASE) / 2;

	reg  [2:0]  state_r;
	reg  [2:0]  state_nxt;
	reg  [2:0]  savedMode_r;
	reg  [2:0]  savedMode_nxt;
	reg  [2:0]  curMode_nxt;
	reg  [3:0]  settleCnt_r;
	reg  [3:0]  settleCnt_nxt;
	reg  [4:0]  pendIdx_r;
	reg  [4:0]  pendIdx_nxt;
	reg         pcLoad_nxt;
	reg  [15:0] vecAddr_nxt;
	reg         sysReset_nxt;
	wire [31:0] srcReq;
	wire [31:0] accepted;
	reg  [4:0]  winIdx;
	reg         anyIrq;
	reg         illegalFetch;
	reg         validMode;
	integer     k;

	// ------------------------------------------------------------------------
	// Serial unit B flag merging onto its two shared vectors
	// ------------------------------------------------------------------------
	// The source flags stay in the serial unit; each arrives here as its own input and is merged per mode.
	wire serBRxVec = serialBI2c ?
		(arbitrationLostFlag | noAckFlag | startSeenFlag | stopSeenFlag) :
		(serialBSpi & serialBReceiveFlag);
	wire serBTxVec = serialBI2c ? (serialBReceiveFlag | serialBTransmitFlag) :
		serialBTransmitFlag;

	// ------------------------------------------------------------------------
	// Per-slot request masking by class
	// ------------------------------------------------------------------------
	genvar g;
	generate
		for (g = 0; g < 32; g = g + 1) begin : gSlot
			assign srcReq[g] = (g == SERB_RX_IDX) ? serBRxVec :
				(g == SERB_TX_IDX) ? serBTxVec : irqReq[g];
			// Slots below the live region and the reset slot never win.
			if (g < USED_LO || g == RESET_IDX) begin : gDead
				assign accepted[g] = 1'b0;
			end else if (NMI_MASK[g]) begin : gNmi
				assign accepted[g] = srcReq[g];
			end else if (PART_MASK[g]) begin : gPart
				assign accepted[g] = srcReq[g] & irqEn[g];
			end else begin : gMask
				assign accepted[g] = srcReq[g] & irqEn[g] & globalIntEn;
			end
		end
	endgenerate

	// ------------------------------------------------------------------------
	// Priority pick: the highest slot wins
	// ------------------------------------------------------------------------
	always @* begin
		winIdx = 5'h00;
		anyIrq = 1'b0;
		for (k = 0; k < 32; k = k + 1) begin
			if (accepted[k]) begin
				winIdx = k[4:0];
				anyIrq = 1'b1;
			end
		end
	end

	// ------------------------------------------------------------------------
	// Fetch checker
	// ------------------------------------------------------------------------
	// Anything outside RAM and flash, including peripheral space, is illegal.
	always @* begin
		illegalFetch = 1'b0;
		if (fetchStb) begin
			if (fetchAddr <= `PMV_PERIPH_HI)
				illegalFetch = 1'b1;
			else if (!((fetchAddr >= RAM_LO && fetchAddr <= RAM_HI) ||
			           fetchAddr >= FLASH_LO))
				illegalFetch = 1'b1;
		end
	end

	// Codes above the deepest level have no storage; such a write is dropped.
	always @* begin
		validMode = (modeSel <= `PMV_MODE_SLEEP4);
	end

	// ------------------------------------------------------------------------
	// Sequencer next state
	// ------------------------------------------------------------------------
	always @* begin
		state_nxt     = state_r;
		savedMode_nxt = savedMode_r;
		curMode_nxt   = curMode_r;
		settleCnt_nxt = settleCnt_r;
		pendIdx_nxt   = pendIdx_r;
		pcLoad_nxt    = 1'b0;
		vecAddr_nxt   = vecAddr_r;
		sysReset_nxt  = 1'b0;
		case (state_r)
			ST_BOOT: begin
				// An erased reset vector parks the part in the deepest level.
				if (resetVecWord == `PMV_BLANK_WORD) begin
					curMode_nxt   = `PMV_MODE_SLEEP4;
					savedMode_nxt = `PMV_MODE_SLEEP4;
					state_nxt     = ST_SLEEP;
				end else begin
					vecAddr_nxt = `PMV_RESET_VEC;
					pcLoad_nxt  = 1'b1;
					curMode_nxt = `PMV_MODE_RUN;
					state_nxt   = ST_RUN;
				end
			end
			ST_RUN: begin
				if (anyIrq) begin
					savedMode_nxt = `PMV_MODE_RUN;
					pendIdx_nxt   = winIdx;
					vecAddr_nxt   = `PMV_TABLE_BASE + {10'h000, winIdx, 1'b0};
					pcLoad_nxt    = 1'b1;
					state_nxt     = ST_SERVICE;
				end else if (modeWr && validMode && modeSel != `PMV_MODE_RUN) begin
					curMode_nxt   = modeSel;
					savedMode_nxt = modeSel;
					state_nxt     = ST_SLEEP;
				end
			end
			ST_SLEEP: begin
				if (anyIrq) begin
					pendIdx_nxt   = winIdx;
					curMode_nxt   = `PMV_MODE_RUN;
					settleCnt_nxt = `PMV_SETTLE_CYC;
					state_nxt     = ST_WAKE;
				end
			end
			ST_WAKE: begin
				// Oscillator settles with every clock enabled but the CPU held.
				if (settleCnt_r == 4'h1) begin
					vecAddr_nxt = `PMV_TABLE_BASE + {10'h000, pendIdx_r, 1'b0};
					pcLoad_nxt  = 1'b1;
					state_nxt   = ST_SERVICE;
				end
				settleCnt_nxt = settleCnt_r - 4'h1;
			end
			ST_SERVICE: begin
				// No nesting: new requests wait until the handler returns.
				if (handlerReturn) begin
					curMode_nxt = savedMode_r;
					state_nxt   = (savedMode_r == `PMV_MODE_RUN) ? ST_RUN : ST_SLEEP;
				end
			end
			default: begin
				state_nxt = ST_BOOT;
			end
		endcase
		if (illegalFetch && cpuRun_r) begin
			sysReset_nxt  = 1'b1;
			state_nxt     = ST_BOOT;
			curMode_nxt   = `PMV_MODE_RUN;
			savedMode_nxt = `PMV_MODE_RUN;
			pcLoad_nxt    = 1'b0;
		end
	end

	// ------------------------------------------------------------------------
	// Sequencer registers
	// ------------------------------------------------------------------------
	always @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			state_r     <= ST_BOOT;
			savedMode_r <= `PMV_MODE_RUN;
			curMode_r   <= `PMV_MODE_RUN;
			settleCnt_r <= 4'h0;
			pendIdx_r   <= 5'h00;
			pcLoad_r    <= 1'b0;
			vecAddr_r   <= 16'h0000;
			sysReset_r  <= 1'b0;
		end else begin
			state_r     <= state_nxt;
			savedMode_r <= savedMode_nxt;
			curMode_r   <= curMode_nxt;
			settleCnt_r <= settleCnt_nxt;
			pendIdx_r   <= pendIdx_nxt;
			pcLoad_r    <= pcLoad_nxt;
			vecAddr_r   <= vecAddr_nxt;
			sysReset_r  <= sysReset_nxt;
		end
	end

	// ------------------------------------------------------------------------
	// Clock and oscillator gating per mode
	// ------------------------------------------------------------------------
	// Decoded from the next mode so the enables change with curMode_r.
	reg cpuN;
	reg mainN;
	reg subN;
	reg auxN;
	reg genN;
	reg xtalN;

	always @* begin
		cpuN  = 1'b0;
		mainN = 1'b0;
		subN  = 1'b0;
		auxN  = 1'b1;
		genN  = 1'b1;
		xtalN = 1'b1;
		case (curMode_nxt)
			`PMV_MODE_RUN: begin
				cpuN  = (state_nxt != ST_WAKE) && (state_nxt != ST_BOOT);
				mainN = 1'b1;
				subN  = 1'b1;
			end
			`PMV_MODE_SLEEP0: begin
				subN = 1'b1;
			end
			`PMV_MODE_SLEEP1: begin
				subN = 1'b1;
				genN = dcoIsMainSrc;
			end
			`PMV_MODE_SLEEP2: begin
				genN = 1'b1;
			end
			`PMV_MODE_SLEEP3: begin
				genN = 1'b0;
			end
			`PMV_MODE_SLEEP4: begin
				auxN  = 1'b0;
				genN  = 1'b0;
				xtalN = 1'b0;
			end
			default: begin
				mainN = 1'b1;
				subN  = 1'b1;
			end
		endcase
	end

	always @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			cpuRun_r       <= 1'b0;
			mainClkEn_r    <= 1'b1;
			subMainClkEn_r <= 1'b1;
			auxClkEn_r     <= 1'b1;
			dcoGenEn_r     <= 1'b1;
			crystalEn_r    <= 1'b1;
		end else begin
			cpuRun_r       <= cpuN;
			mainClkEn_r    <= mainN;
			subMainClkEn_r <= subN;
			auxClkEn_r     <= auxN;
			dcoGenEn_r     <= genN;
			crystalEn_r    <= xtalN;
		end
	end

	// ------------------------------------------------------------------------
	// Boot loader key word decode
	// ------------------------------------------------------------------------
	// The word is flash content, so it is simply decoded every cycle.
	always @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			bootLoaderOff_r <= 1'b0;
			eraseGuard_r    <= 1'b0;
		end else begin
			bootLoaderOff_r <= (bootLoaderKeyWord == `PMV_KEY_NO_BOOT);
			eraseGuard_r    <= (bootLoaderKeyWord == `PMV_KEY_NO_ERASE);
		end
	end

endmodule
`default_nettype wire

// ===== testbench/pmv_mode_monitor.sv
// Port checker for the power mode and vector controller.
// Assumes a single clock domain and the wake and boot timing of the sequencer.
`default_nettype none

// ----------------------------------------------------------------------------
// Checker
// ----------------------------------------------------------------------------
module pmv_mode_monitor (
	input wire logic        clk,
	input wire logic        resetn,
	input wire logic [31:0] irqReq,
	input wire logic        fetchStb,
	input wire logic [15:0] fetchAddr,
	input wire logic [15:0] bootLoaderKeyWord,
	input wire logic        cpuRun_r,
	input wire logic        mainClkEn_r,
	input wire logic        subMainClkEn_r,
	input wire logic        auxClkEn_r,
	input wire logic        dcoGenEn_r,
	input wire logic        crystalEn_r,
	input wire logic [2:0]  curMode_r,
	input wire logic        pcLoad_r,
	input wire logic [15:0] vecAddr_r,
	input wire logic        sysReset_r,
	input wire logic        bootLoaderOff_r,
	input wire logic        eraseGuard_r
);
	timeunit 1ns;
	timeprecision 100ps;
	default clocking cb @(posedge clk); endclocking
	default disable iff (!resetn);

	// Clock gating per mode; the bench walks every level.
	property p_sleep_halt; curMode_r != 3'h0 |-> !cpuRun_r && !mainClkEn_r; endproperty
	a_sleep_halt: assert property (p_sleep_halt) else $error("cpu alive in sleep");
	property p_run_clk; cpuRun_r |-> mainClkEn_r && subMainClkEn_r && auxClkEn_r; endproperty
	a_run_clk: assert property (p_run_clk) else $error("clock off while running");
	property p_deep; curMode_r == 3'h5 |-> !auxClkEn_r && !dcoGenEn_r && !crystalEn_r; endproperty
	a_deep: assert property (p_deep) else $error("deepest level leaves a clock on");
	// Wake must reach a vector load within 98 cycles, just under one microsecond.
	property p_wake; (curMode_r != 3'h0) ##1 (curMode_r == 3'h0) |-> ##[0:98] pcLoad_r; endproperty
	a_wake: assert property (p_wake) else $error("wake too slow");
	property p_nmi; irqReq[30] && curMode_r != 3'h0 |=> curMode_r == 3'h0; endproperty
	a_nmi: assert property (p_nmi) else $error("nonmaskable source ignored");
	property p_bad_fetch; fetchStb && cpuRun_r && fetchAddr <= 16'h01FF |=> sysReset_r; endproperty
	a_bad_fetch: assert property (p_bad_fetch) else $error("illegal fetch missed");
	property p_vec; pcLoad_r |-> vecAddr_r >= 16'hFFE0 && !vecAddr_r[0]; endproperty
	a_vec: assert property (p_vec) else $error("vector outside used table");
	property p_key; $past(resetn) |-> bootLoaderOff_r == ($past(bootLoaderKeyWord) == 16'hAA55)
		&& eraseGuard_r == ($past(bootLoaderKeyWord) == 16'h0000); endproperty
	a_key: assert property (p_key) else $error("key word decode wrong");
endmodule

bind pmv_power_mode_and_vector_ctrl pmv_mode_monitor u_mon (.*);
`default_nettype wire

// ===== testbench/pmv_cpu_model.sv
// Behavioural CPU core: answers each handler vector load with a return.
// Assumes pcLoad is a one-cycle pulse; boot loads at the reset vector are not handlers.
`default_nettype none

// ----------------------------------------------------------------------------
// CPU model
// ----------------------------------------------------------------------------
module pmv_cpu_model #(
	parameter integer RET_CYC = 3
) (
	input  wire logic        clk,
	input  wire logic        resetn,
	input  wire logic        pcLoad,
	input  wire logic [15:0] vecAddr,
	output var  logic        handlerReturn
);
	timeunit 1ns;
	timeprecision 100ps;
	initial handlerReturn = 1'b0;
	// A longer RET_CYC models a slow handler; the return is one clean cycle.
	always @(posedge clk) begin
		if (resetn && pcLoad && vecAddr != 16'hFFFE) begin
			repeat (RET_CYC) @(posedge clk);
			#1 handlerReturn = 1'b1;
			@(posedge clk);
			#1 handlerReturn = 1'b0;
		end
	end
endmodule
`default_nettype wire

// ===== testbench/pmv_tb.sv
// Self-checking bench for the power mode and vector controller.
// Assumes the checker is bound to the design and the CPU model answers handlers.
`default_nettype none

// ----------------------------------------------------------------------------
// Bench
// ----------------------------------------------------------------------------
module tb;
	timeunit 1ns;
	timeprecision 100ps;
	logic        clk, resetn, modeWr, dcoIsMainSrc, globalIntEn, serialBI2c, serialBSpi;
	logic        serialBReceiveFlag, serialBTransmitFlag, arbitrationLostFlag, noAckFlag;
	logic        startSeenFlag, stopSeenFlag, fetchStb;
	logic [2:0]  modeSel;
	logic [31:0] irqReq, irqEn;
	logic [15:0] fetchAddr, resetVecWord, bootLoaderKeyWord;
	wire logic   handlerReturn, cpuRun_r, mainClkEn_r, subMainClkEn_r, auxClkEn_r;
	wire logic   dcoGenEn_r, crystalEn_r, pcLoad_r, sysReset_r, bootLoaderOff_r, eraseGuard_r;
	wire logic [2:0]  curMode_r;
	wire logic [15:0] vecAddr_r;
	integer      errors, checks;

	pmv_power_mode_and_vector_ctrl dut (.*);
	pmv_cpu_model u_cpu (.clk(clk), .resetn(resetn), .pcLoad(pcLoad_r), .vecAddr(vecAddr_r),
		.handlerReturn(handlerReturn));

	// Free-running 100 MHz clock.
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	task automatic chk(input string what, input logic [15:0] got, input logic [15:0] exp);
		checks = checks + 1;
		if (got !== exp) begin
			errors = errors + 1;
			$display("[FAIL] %s expected %h seen %h", what, exp, got);
		end
	endtask

	task automatic test_done();
		if (errors == 0 && checks > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask

	// Inputs move 1 ns after the edge so the design never races the bench.
	task automatic tick(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask

	task automatic do_reset(input logic [15:0] vec);
		resetn = 1'b0;
		resetVecWord = vec;
		tick(6);
		resetn = 1'b1;
		tick(1);
	endtask

	task automatic set_mode(input logic [2:0] m);
		modeSel = m;
		modeWr = 1'b1;
		tick(1);
		modeWr = 1'b0;
		tick(1);
	endtask

	// Waits for a vector load, drops every request, then lets the handler return.
	task automatic take(input logic [15:0] exp);
		int n;
		n = 0;
		while (pcLoad_r !== 1'b1 && n < 120) begin
			tick(1);
			n++;
		end
		chk("load", pcLoad_r, 1'b1);
		chk("vector", vecAddr_r, exp);
		irqReq = 32'h0;
		{serialBReceiveFlag, serialBTransmitFlag, arbitrationLostFlag} = 3'h0;
		{noAckFlag, startSeenFlag, stopSeenFlag} = 3'h0;
		tick(6);
	endtask

	task automatic no_take();
		repeat (10) begin
			tick(1);
			chk("quiet", pcLoad_r, 1'b0);
		end
		irqReq = 32'h0;
	endtask

	task automatic t_boot();
		do_reset(16'hFFFF);
		chk("blank mode", curMode_r, 3'h5);
		chk("blank clk", {cpuRun_r, auxClkEn_r, crystalEn_r}, 3'h0);
		irqEn = 32'h0;
		globalIntEn = 1'b0;
		irqReq[30] = 1'b1;
		take(16'hFFFC);
		chk("nmi back", curMode_r, 3'h5);
	endtask

	// Every sleep level: gating, wake to a vector, return to the same level.
	task automatic t_levels();
		for (int l = 0; l < 5; l++) begin
			do_reset(16'h8000);
			set_mode(3'(l + 1));
			chk("mode", curMode_r, 16'(l + 1));
			chk("halt", {cpuRun_r, mainClkEn_r}, 2'h0);
			chk("sub", subMainClkEn_r, l <= 1);
			chk("aux", auxClkEn_r, l <= 3);
			if (l > 0)
				chk("gen", dcoGenEn_r, l == 2);
			irqEn = 32'hFFFFFFFF;
			globalIntEn = 1'b1;
			irqReq[20] = 1'b1;
			take(16'hFFE8);
			chk("return", curMode_r, 16'(l + 1));
		end
		do_reset(16'h8000);
		dcoIsMainSrc = 1'b1;
		set_mode(3'h2);
		chk("gen kept", dcoGenEn_r, 1'b1);
		dcoIsMainSrc = 1'b0;
	endtask

	task automatic t_mask();
		do_reset(16'h8000);
		set_mode(3'h6);
		chk("bad code", curMode_r, 3'h0);
		chk("run clk", {cpuRun_r, mainClkEn_r, subMainClkEn_r, auxClkEn_r}, 4'hF);
		chk("run osc", {dcoGenEn_r, crystalEn_r}, 2'h3);
		globalIntEn = 1'b0;
		irqEn = 32'h0;
		irqReq[29] = 1'b1;
		no_take();
		irqEn[29] = 1'b1;
		irqReq[29] = 1'b1;
		take(16'hFFFA);
		irqEn = 32'hFFFFFFFF;
		irqReq[20] = 1'b1;
		no_take();
		globalIntEn = 1'b1;
		irqReq[10] = 1'b1;
		no_take();
		irqReq = 32'h0210_0000;
		take(16'hFFF2);
	endtask

	task automatic t_serial();
		serialBI2c = 1'b1;
		for (int i = 0; i < 4; i++) begin
			{arbitrationLostFlag, noAckFlag, startSeenFlag, stopSeenFlag} = 4'h1 << i;
			take(16'hFFEE);
		end
		serialBReceiveFlag = 1'b1;
		take(16'hFFEC);
		{serialBI2c, serialBSpi} = 2'h1;
		serialBReceiveFlag = 1'b1;
		take(16'hFFEE);
		serialBTransmitFlag = 1'b1;
		take(16'hFFEC);
		{serialBI2c, serialBSpi} = 2'h0;
		serialBReceiveFlag = 1'b1;
		no_take();
		serialBReceiveFlag = 1'b0;
		serialBTransmitFlag = 1'b1;
		take(16'hFFEC);
	endtask

	task automatic t_fetch_key();
		{fetchStb, fetchAddr} = {1'b1, 16'h8000};
		tick(1);
		chk("good fetch", sysReset_r, 1'b0);
		fetchAddr = 16'h0100;
		tick(1);
		fetchStb = 1'b0;
		chk("bad fetch", sysReset_r, 1'b1);
		tick(1);
		chk("reboot", pcLoad_r, 1'b1);
		chk("reboot vector", vecAddr_r, 16'hFFFE);
		bootLoaderKeyWord = 16'hAA55;
		tick(2);
		chk("no boot", {bootLoaderOff_r, eraseGuard_r}, 2'h2);
		bootLoaderKeyWord = 16'h0000;
		tick(2);
		chk("no erase", {bootLoaderOff_r, eraseGuard_r}, 2'h1);
	endtask

	// Main sequence.
	initial begin
		errors = 0;
		checks = 0;
		{resetn, modeWr, dcoIsMainSrc, globalIntEn, serialBI2c, serialBSpi, fetchStb} = 7'h0;
		{serialBReceiveFlag, serialBTransmitFlag, arbitrationLostFlag} = 3'h0;
		{noAckFlag, startSeenFlag, stopSeenFlag} = 3'h0;
		{modeSel, irqReq, irqEn} = 67'h0;
		{fetchAddr, resetVecWord, bootLoaderKeyWord} = {16'h8000, 16'h8000, 16'h1234};
		t_boot();
		t_levels();
		t_mask();
		t_serial();
		t_fetch_key();
		test_done();
	end

	// Watchdog far beyond the few hundred cycles the scenarios need.
	initial begin
		#200000;
		errors = errors + 1;
		test_done();
	end
endmodule
`default_nettype wire
